// ==== periph_reset_pkg.sv ====
// Constants for the peripheral reset control block: offsets, field masks,
// reset values and bit positions of each reset-control field.
// Assumes an APB slave with 32-bit data and byte addresses.
package periph_reset_pkg;
  localparam logic [11:0] FAST_RST_OFFSET = 12'h00C;
  localparam logic [11:0] SLOW_RST_OFFSET = 12'h010;
  localparam logic [31:0] FAST_RST_RESET  = 32'h00000000;
  localparam logic [31:0] SLOW_RST_RESET  = 32'h00000000;
  // Writable bits; everything else is reserved and reads zero
  localparam logic [31:0] FAST_RST_MASK   = 32'h0038FFFD;
  localparam logic [31:0] SLOW_RST_MASK   = 32'h3E7EC9F6;
  // Fast bus field positions
  localparam int ALTFUNC_IO_BIT    = 0;
  localparam int PORT_A_BIT        = 2;
  localparam int PORT_COUNT        = 7;
  localparam int CONV_ZERO_BIT     = 9;
  localparam int CONV_ONE_BIT      = 10;
  localparam int TIMER_ZERO_BIT    = 11;
  localparam int SYNC_SER_ZERO_BIT = 12;
  localparam int TIMER_SEVEN_BIT   = 13;
  localparam int SERIAL_ZERO_BIT   = 14;
  localparam int CONV_TWO_BIT      = 15;
  localparam int TIMER_EIGHT_BIT   = 19;
  localparam int TIMER_NINE_BIT    = 20;
  localparam int TIMER_TEN_BIT     = 21;
  // Slow bus field positions
  localparam int TIMER_TWO_BIT      = 1;
  localparam int TIMER_THREE_BIT    = 2;
  localparam int TIMER_FIVE_BIT     = 4;
  localparam int TIMER_SIX_BIT      = 5;
  localparam int TIMER_ELEVEN_BIT   = 6;
  localparam int TIMER_TWELVE_BIT   = 7;
  localparam int TIMER_THIRTEEN_BIT = 8;
  localparam int WATCHDOG_BIT       = 11;
  localparam int SYNC_SER_ONE_BIT   = 14;
  localparam int SYNC_SER_TWO_BIT   = 15;
  localparam int SERIAL_ONE_BIT     = 17;
  localparam int SERIAL_TWO_BIT     = 18;
  localparam int ASYNC_THREE_BIT    = 19;
  localparam int ASYNC_FOUR_BIT     = 20;
  localparam int I2C_ZERO_BIT       = 21;
  localparam int I2C_ONE_BIT        = 22;
  localparam int CAN_ZERO_BIT       = 25;
  localparam int CAN_ONE_BIT        = 26;
  localparam int BACKUP_IF_BIT      = 27;
  localparam int POWER_CTL_BIT      = 28;
  localparam int DAC_UNIT_BIT       = 29;
endpackage

// ==== rst_bank_if.sv ====
// Interface between the register decoder and the reset bank.
// Assumes one clock domain, pclk.
`timescale 1ns/1ps
`default_nettype none
interface rst_bank_if;
  logic        wr_fast;
  logic        wr_slow;
  logic [31:0] wdata;
  logic [31:0] fast_q;
  logic [31:0] slow_q;
  modport ctl  (output wr_fast, output wr_slow, output wdata, input fast_q, input slow_q);
  modport bank (input wr_fast, input wr_slow, input wdata, output fast_q, output slow_q);
endinterface
`default_nettype wire

// ==== rst_bank.sv ====
// Reset bank: the two reset-control words, written by software only.
// Assumes writes arrive as one-cycle strobes on the pclk domain.
`timescale 1ns/1ps
`default_nettype none
module rst_bank (
  input  wire logic   pclk,
  input  wire logic   presetn,
  rst_bank_if.bank    bus
);
  ////////////////////////////////////////////////////////////////////////
  // Fast bus word; reserved positions masked so they stay zero
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bus.fast_q <= periph_reset_pkg::FAST_RST_RESET;
    end else if (bus.wr_fast) begin
      bus.fast_q <= bus.wdata & periph_reset_pkg::FAST_RST_MASK;
    end
  end

  // Slow bus word; only software writes and presetn change it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bus.slow_q <= periph_reset_pkg::SLOW_RST_RESET;
    end else if (bus.wr_slow) begin
      bus.slow_q <= bus.wdata & periph_reset_pkg::SLOW_RST_MASK;
    end
  end

  a_fast_hold: assert property (@(posedge pclk) disable iff (!presetn)
    !$past(bus.wr_fast) |-> $stable(bus.fast_q))
    else $error("fast word changed without a write");
  a_slow_hold: assert property (@(posedge pclk) disable iff (!presetn)
    !$past(bus.wr_slow) |-> $stable(bus.slow_q))
    else $error("slow word changed without a write");
endmodule
`default_nettype wire

// ==== periph_reset_ctl.sv ====
// Peripheral reset control: APB slave with two reset-control registers
// driving one active-high synchronous reset line per peripheral.
// Assumes APB3 master on pclk; peripherals sample their reset on pclk.
//
// Implementation choice: the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module periph_reset_ctl (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Fast bus peripheral resets
  output logic             altfunc_io_rst_ctl,
  output logic [6:0]       port_rst_ctl,
  output logic             converter_zero_rst_ctl,
  output logic             converter_one_rst_ctl,
  output logic             converter_two_rst_ctl,
  output logic             timer_zero_rst_ctl,
  output logic             sync_serial_zero_rst_ctl,
  output logic             timer_seven_rst_ctl,
  output logic             serial_zero_rst_ctl,
  output logic             timer_eight_rst_ctl,
  output logic             timer_nine_rst_ctl,
  output logic             timer_ten_rst_ctl,
  // Slow bus peripheral resets
  output logic             timer_two_rst_ctl,
  output logic             timer_three_rst_ctl,
  output logic             timer_five_rst_ctl,
  output logic             timer_six_rst_ctl,
  output logic             timer_eleven_rst_ctl,
  output logic             timer_twelve_rst_ctl,
  output logic             timer_thirteen_rst_ctl,
  output logic             window_watchdog_rst_ctl,
  output logic             sync_serial_one_rst_ctl,
  output logic             sync_serial_two_rst_ctl,
  output logic             serial_one_rst_ctl,
  output logic             serial_two_rst_ctl,
  output logic             async_three_rst_ctl,
  output logic             async_four_rst_ctl,
  output logic             i2c_zero_rst_ctl,
  output logic             i2c_one_rst_ctl,
  output logic             can_zero_rst_ctl,
  output logic             can_one_rst_ctl,
  output logic             backup_if_rst_ctl,
  output logic             power_ctl_rst_ctl,
  output logic             dac_unit_rst_ctl
);
  rst_bank_if bank_bus ();

  logic setup_ok;
  logic hit_fast;
  logic hit_slow;
  logic busy;
  logic [31:0] fast_w;
  logic [31:0] slow_w;

  ////////////////////////////////////////////////////////////////////////
  // Address decode, exact match on all 12 address bits, so unaligned addresses miss
  function automatic logic hit(input logic [11:0] a, input logic [11:0] off);
    hit = (a == off);
  endfunction

  assign setup_ok = psel && !penable;
  assign hit_fast = hit(paddr, periph_reset_pkg::FAST_RST_OFFSET);
  assign hit_slow = hit(paddr, periph_reset_pkg::SLOW_RST_OFFSET);

  ////////////////////////////////////////////////////////////////////////
  // No wait state: pready rises in the access cycle, from a flop
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      busy <= 1'b0;
    end else begin
      busy <= setup_ok;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
    end else begin
      pready <= setup_ok;
    end
  end

  // Unmapped address answers with an error, nothing stored
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pslverr <= 1'b0;
    end else begin
      pslverr <= setup_ok && !hit_fast && !hit_slow;
    end
  end

  // Read data captured in setup so it leaves a flop
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
    end else if (setup_ok && !pwrite) begin
      prdata <= hit_fast ? bank_bus.fast_q :
                hit_slow ? bank_bus.slow_q : 32'h00000000;
    end
  end

  // Write strobes at the completing access edge
  assign bank_bus.wr_fast = psel && penable && pready && pwrite && hit_fast;
  assign bank_bus.wr_slow = psel && penable && pready && pwrite && hit_slow;
  assign bank_bus.wdata   = pwdata;

  rst_bank u_bank (
    .pclk    (pclk),
    .presetn (presetn),
    .bus     (bank_bus.bank)
  );

  ////////////////////////////////////////////////////////////////////////
  // Reset lines follow the words directly: a clear releases the peripheral
  // on the following edge, with no extra flop in the way
  assign fast_w = bank_bus.fast_q;
  assign slow_w = bank_bus.slow_q;

  always_comb begin
    altfunc_io_rst_ctl       = fast_w[periph_reset_pkg::ALTFUNC_IO_BIT];
    port_rst_ctl             = fast_w[periph_reset_pkg::PORT_A_BIT +: 7];
    converter_zero_rst_ctl   = fast_w[periph_reset_pkg::CONV_ZERO_BIT];
    converter_one_rst_ctl    = fast_w[periph_reset_pkg::CONV_ONE_BIT];
    timer_zero_rst_ctl       = fast_w[periph_reset_pkg::TIMER_ZERO_BIT];
    sync_serial_zero_rst_ctl = fast_w[periph_reset_pkg::SYNC_SER_ZERO_BIT];
    timer_seven_rst_ctl      = fast_w[periph_reset_pkg::TIMER_SEVEN_BIT];
    serial_zero_rst_ctl      = fast_w[periph_reset_pkg::SERIAL_ZERO_BIT];
    converter_two_rst_ctl    = fast_w[periph_reset_pkg::CONV_TWO_BIT];
    timer_eight_rst_ctl      = fast_w[periph_reset_pkg::TIMER_EIGHT_BIT];
    timer_nine_rst_ctl       = fast_w[periph_reset_pkg::TIMER_NINE_BIT];
    timer_ten_rst_ctl        = fast_w[periph_reset_pkg::TIMER_TEN_BIT];
  end

  always_comb begin
    timer_two_rst_ctl       = slow_w[periph_reset_pkg::TIMER_TWO_BIT];
    timer_three_rst_ctl     = slow_w[periph_reset_pkg::TIMER_THREE_BIT];
    timer_five_rst_ctl      = slow_w[periph_reset_pkg::TIMER_FIVE_BIT];
    timer_six_rst_ctl       = slow_w[periph_reset_pkg::TIMER_SIX_BIT];
    timer_eleven_rst_ctl    = slow_w[periph_reset_pkg::TIMER_ELEVEN_BIT];
    timer_twelve_rst_ctl    = slow_w[periph_reset_pkg::TIMER_TWELVE_BIT];
    timer_thirteen_rst_ctl  = slow_w[periph_reset_pkg::TIMER_THIRTEEN_BIT];
    window_watchdog_rst_ctl = slow_w[periph_reset_pkg::WATCHDOG_BIT];
    sync_serial_one_rst_ctl = slow_w[periph_reset_pkg::SYNC_SER_ONE_BIT];
    sync_serial_two_rst_ctl = slow_w[periph_reset_pkg::SYNC_SER_TWO_BIT];
    serial_one_rst_ctl      = slow_w[periph_reset_pkg::SERIAL_ONE_BIT];
    serial_two_rst_ctl      = slow_w[periph_reset_pkg::SERIAL_TWO_BIT];
    async_three_rst_ctl     = slow_w[periph_reset_pkg::ASYNC_THREE_BIT];
    async_four_rst_ctl      = slow_w[periph_reset_pkg::ASYNC_FOUR_BIT];
    i2c_zero_rst_ctl        = slow_w[periph_reset_pkg::I2C_ZERO_BIT];
    i2c_one_rst_ctl         = slow_w[periph_reset_pkg::I2C_ONE_BIT];
    can_zero_rst_ctl        = slow_w[periph_reset_pkg::CAN_ZERO_BIT];
    can_one_rst_ctl         = slow_w[periph_reset_pkg::CAN_ONE_BIT];
    backup_if_rst_ctl       = slow_w[periph_reset_pkg::BACKUP_IF_BIT];
    power_ctl_rst_ctl       = slow_w[periph_reset_pkg::POWER_CTL_BIT];
    dac_unit_rst_ctl        = slow_w[periph_reset_pkg::DAC_UNIT_BIT];
  end

  ////////////////////////////////////////////////////////////////////////
  // Checks
  a_fast_write_lands: assert property (@(posedge pclk) disable iff (!presetn)
    bank_bus.wr_fast |=> fast_w == ($past(pwdata) & periph_reset_pkg::FAST_RST_MASK))
    else $error("fast write not stored");
  a_slow_reserved: assert property (@(posedge pclk) disable iff (!presetn)
    (slow_w & ~periph_reset_pkg::SLOW_RST_MASK) == 32'h00000000)
    else $error("slow reserved bit set");
  a_fast_reserved: assert property (@(posedge pclk) disable iff (!presetn)
    fast_w[1] == 1'b0 && fast_w[31:22] == 10'h000)
    else $error("fast reserved bit set");
  a_ports_order: assert property (@(posedge pclk) disable iff (!presetn)
    bank_bus.wr_fast |=> port_rst_ctl == $past(pwdata[8:2]))
    else $error("port reset order wrong");
  a_timer_hi: assert property (@(posedge pclk) disable iff (!presetn)
    bank_bus.wr_fast |=> timer_ten_rst_ctl == $past(pwdata[21]) &&
      timer_eight_rst_ctl == $past(pwdata[19]))
    else $error("timer ten/eight reset wrong");
  a_power_dac: assert property (@(posedge pclk) disable iff (!presetn)
    bank_bus.wr_slow |=> power_ctl_rst_ctl == $past(pwdata[28]) &&
      dac_unit_rst_ctl == $past(pwdata[29]) && backup_if_rst_ctl == $past(pwdata[27]))
    else $error("power/dac/backup reset wrong");
  a_slow_timers: assert property (@(posedge pclk) disable iff (!presetn)
    bank_bus.wr_slow |=> timer_thirteen_rst_ctl == $past(pwdata[8]) &&
      timer_two_rst_ctl == $past(pwdata[1]))
    else $error("slow timer reset wrong");
  a_release_next: assert property (@(posedge pclk) disable iff (!presetn)
    bank_bus.wr_slow && !pwdata[28] |=> !power_ctl_rst_ctl)
    else $error("release not on next cycle");
  a_read_back: assert property (@(posedge pclk) disable iff (!presetn)
    setup_ok && !pwrite && hit_fast && !bank_bus.wr_fast |=> prdata == $past(fast_w))
    else $error("read back mismatch");
  a_ready_once: assert property (@(posedge pclk) disable iff (!presetn)
    pready |=> !pready)
    else $error("pready held too long");
endmodule
`default_nettype wire

// ==== periph_reset_ctl_tb.sv ====
// Self-checking bench for the peripheral reset control block: APB traffic
// noted in a queue, replies and every reset output checked by a monitor.
// Assumes one-cycle APB answers and outputs that follow the stored bits.
`timescale 1ns/1ps
`default_nettype none
module periph_reset_ctl_tb;
  typedef struct packed {
    logic        rd;
    logic [11:0] a;
    logic [31:0] v;
    logic        err;
  } note_s;
  // Own copies of the writable bits, so a writable bit missing from the design's masks shows
  localparam logic [31:0] FAST_W = 32'h0038FFFD;
  localparam logic [31:0] SLOW_W = 32'h3E7EC9F6;
  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  wire  [31:0] fast_o;
  wire  [31:0] slow_o;
  logic [31:0] fast_s;
  logic [31:0] slow_s;
  logic [31:0] fast_m;
  logic [31:0] slow_m;
  note_s       notes[$];
  note_s       n;
  int          seed;
  int          mismatches;
  int          samples_checked;
  logic [11:0] bad_a[5] = '{12'h000, 12'h008, 12'h00D, 12'h014, 12'hFFC};
  //////////////////////////////////////////////////////////////////////
  // Reserved positions read as zero in the packed output words
  assign fast_o[31:22] = 10'h000;
  assign fast_o[18:16] = 3'h0;
  assign fast_o[1]     = 1'b0;
  assign slow_o[31:30] = 2'h0;
  assign slow_o[24:23] = 2'h0;
  assign slow_o[16]    = 1'b0;
  assign slow_o[13:12] = 2'h0;
  assign slow_o[10:9]  = 2'h0;
  assign slow_o[3]     = 1'b0;
  assign slow_o[0]     = 1'b0;
  periph_reset_ctl u_periph_reset_ctl (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr),
    .altfunc_io_rst_ctl(fast_o[0]), .port_rst_ctl(fast_o[8:2]),
    .converter_zero_rst_ctl(fast_o[9]), .converter_one_rst_ctl(fast_o[10]),
    .timer_zero_rst_ctl(fast_o[11]), .sync_serial_zero_rst_ctl(fast_o[12]),
    .timer_seven_rst_ctl(fast_o[13]), .serial_zero_rst_ctl(fast_o[14]),
    .converter_two_rst_ctl(fast_o[15]), .timer_eight_rst_ctl(fast_o[19]),
    .timer_nine_rst_ctl(fast_o[20]), .timer_ten_rst_ctl(fast_o[21]),
    .timer_two_rst_ctl(slow_o[1]), .timer_three_rst_ctl(slow_o[2]),
    .timer_five_rst_ctl(slow_o[4]), .timer_six_rst_ctl(slow_o[5]),
    .timer_eleven_rst_ctl(slow_o[6]), .timer_twelve_rst_ctl(slow_o[7]),
    .timer_thirteen_rst_ctl(slow_o[8]), .window_watchdog_rst_ctl(slow_o[11]),
    .sync_serial_one_rst_ctl(slow_o[14]), .sync_serial_two_rst_ctl(slow_o[15]),
    .serial_one_rst_ctl(slow_o[17]), .serial_two_rst_ctl(slow_o[18]),
    .async_three_rst_ctl(slow_o[19]), .async_four_rst_ctl(slow_o[20]),
    .i2c_zero_rst_ctl(slow_o[21]), .i2c_one_rst_ctl(slow_o[22]),
    .can_zero_rst_ctl(slow_o[25]), .can_one_rst_ctl(slow_o[26]),
    .backup_if_rst_ctl(slow_o[27]), .power_ctl_rst_ctl(slow_o[28]),
    .dac_unit_rst_ctl(slow_o[29]));
  //////////////////////////////////////////////////////////////////////
  // Clock at 10 MHz
  always #50 pclk = ~pclk;
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
    samples_checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("mismatch at %0t: %s got %h expected %h", $time, msg, seen, exp);
    end
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  // One APB access; request held until pready, no release so back-to-back works
  task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] d,
                      input logic [31:0] exp, input logic err);
    int k;
    k = 0;
    notes.push_back('{!wr, a, exp, err});
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    if (pready !== 1'b1) begin
      mismatches++;
      $display("mismatch at %0t: no reply", $time);
      results();
    end
  endtask
  task automatic idle();
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic wr_reg(input logic [11:0] a, input logic [31:0] d);
    logic err;
    err = !(a == 12'h00C || a == 12'h010);
    if (a == 12'h00C) fast_s = d & FAST_W;
    if (a == 12'h010) slow_s = d & SLOW_W;
    // Software keeps reserved positions at zero on mapped registers
    xfer(1'b1, a, (a == 12'h00C) ? (d & FAST_W) : (a == 12'h010) ? (d & SLOW_W) : d,
         (a == 12'h00C) ? fast_s : slow_s, err);
  endtask
  task automatic rd_reg(input logic [11:0] a);
    xfer(1'b0, a, $random(seed), (a == 12'h00C) ? fast_s : (a == 12'h010) ? slow_s : 32'h0,
         !(a == 12'h00C || a == 12'h010));
  endtask
  //////////////////////////////////////////////////////////////////////
  // Monitor: outputs against the model each cycle, replies against notes
  always @(posedge pclk) begin
    if (!presetn) begin
      fast_m = 32'h0;
      slow_m = 32'h0;
    end
    check(fast_o[21:19], fast_m[21:19], "fast timers");
    check(fast_o[8:2], fast_m[8:2], "ports");
    check(fast_o[0], fast_m[0], "altfunc io");
    check(slow_o[29:28], slow_m[29:28], "power and dac");
    check(slow_o[27], slow_m[27], "backup");
    check(slow_o[8:1], slow_m[8:1], "slow timers");
    check(fast_o ^ slow_o, fast_m ^ slow_m, "all outputs");
    if (psel && penable && pready) begin
      n = notes.pop_front();
      check(pslverr, n.err, "error reply");
      if (n.rd) check(prdata, n.v, "read data");
      else if (!n.err && n.a == 12'h00C) fast_m = n.v;
      else if (!n.err && n.a == 12'h010) slow_m = n.v;
    end
  end
  //////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    pclk = 1'b0;
    presetn = 1'b0;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {fast_s, slow_s, fast_m, slow_m} = '0;
    {mismatches, samples_checked} = '0;
    seed = 37752;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd_reg(12'h00C);
    rd_reg(12'h010);
    idle();
    $display("test reset_values done");
    for (int i = 0; i < 32; i++) begin
      wr_reg(12'h00C, 32'h1 << i);
      wr_reg(12'h010, 32'h1 << i);
      rd_reg(12'h00C);
      rd_reg(12'h010);
    end
    wr_reg(12'h00C, 32'h0);
    wr_reg(12'h010, 32'h0);
    idle();
    $display("test walking_bits done");
    repeat (20) begin
      wr_reg(12'h00C, $random(seed));
      wr_reg(12'h010, $random(seed));
      idle();
      rd_reg(12'h00C);
      rd_reg(12'h010);
    end
    idle();
    $display("test random_words done");
    foreach (bad_a[i]) begin
      wr_reg(bad_a[i], 32'hFFFFFFFF);
      rd_reg(bad_a[i]);
    end
    rd_reg(12'h00C);
    rd_reg(12'h010);
    idle();
    $display("test unmapped done");
    wr_reg(12'h00C, 32'hFFFFFFFF);
    wr_reg(12'h010, 32'hFFFFFFFF);
    idle();
    presetn <= 1'b0;
    fast_s = 32'h0;
    slow_s = 32'h0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd_reg(12'h00C);
    rd_reg(12'h010);
    idle();
    $display("test second_reset done");
    results();
  end
endmodule
`default_nettype wire
